// ---- include/cabx_params.svh ----
// Purpose: constants of the add, shift, bit and jump execution block
// Assumes: included by the package and by every design file
// Notes:   definitions only
`ifndef CABX_PARAMS_SVH
`define CABX_PARAMS_SVH
`define CABX_DW        8
`define CABX_FA_W      7
`define CABX_BS_W      3
`define CABX_OFS_W     9
`define CABX_PC_W      15
`define CABX_NIB_W     4
`define CABX_ACC_RST   8'h00
`define CABX_FA_RST    7'h00
`define CABX_FLAG_RST  1'b0
`define CABX_PC_RST    15'h0000
`define CABX_SLOT_CYC  1
`endif

// ---- include/cabx_pkg.sv ----
// Purpose: types of the add, shift, bit and jump execution block
// Assumes: cabx_params.svh on the include path
// Notes:   operation codes come already decoded from the instruction decoder
`include "cabx_params.svh"
package cabx_pkg;
	typedef enum logic [2:0] {
		add_acc_to_file,
		add_acc_file_with_carry,
		arith_shift_right_file,
		clear_file_bit,
		test_bit_skip_if_clear,
		relative_jump
	} cabx_op_t;
	typedef enum logic {
		cabx_st_exec,
		cabx_st_nop
	} cabx_state_t;
endpackage : cabx_pkg

// ---- src/cabx_alu.sv ----
// Purpose: combinational result and flag generation
// Assumes: operands already forwarded and stable for the cycle
// Notes:   no state; main block decides when results are stored
`timescale 1ns/100ps
`include "cabx_params.svh"
module cabx_alu (
	input  wire cabx_pkg::cabx_op_t        op,        // decoded operation
	input  wire logic [`CABX_DW-1:0]       acc,       // working register
	input  wire logic [`CABX_DW-1:0]       fdat,      // file operand
	input  wire logic                      carry_in,  // current carry flag
	input  wire logic [`CABX_BS_W-1:0]     bit_sel,   // selected bit
	output logic      [`CABX_DW-1:0]       res,       // result byte
	output logic                           c_out,     // new carry
	output logic                           dc_out,    // new digit carry
	output logic                           z_out,     // new zero
	output logic                           is_arith,  // carry, digit carry, zero change
	output logic                           is_shift,  // carry and zero change
	output logic                           bit_val    // tested bit value
);
	wire                     use_c;
	wire [`CABX_DW:0]        sum;
	wire [`CABX_NIB_W:0]     nib;
	wire [`CABX_DW-1:0]      keep_mask;
	wire [`CABX_DW-1:0]      shifted;

	assign is_arith = (op == cabx_pkg::add_acc_to_file) || (op == cabx_pkg::add_acc_file_with_carry);
	assign is_shift = (op == cabx_pkg::arith_shift_right_file);
	assign use_c    = (op == cabx_pkg::add_acc_file_with_carry) & carry_in;
	assign sum      = {1'b0, acc} + {1'b0, fdat} + {{`CABX_DW{1'b0}}, use_c};
	assign nib      = {1'b0, acc[`CABX_NIB_W-1:0]} + {1'b0, fdat[`CABX_NIB_W-1:0]}
	                + {{`CABX_NIB_W{1'b0}}, use_c};
	assign shifted  = {fdat[`CABX_DW-1], fdat[`CABX_DW-1:1]};

	genvar i;
	generate
		for (i = 0; i < `CABX_DW; i++) begin : g_mask
			assign keep_mask[i] = (bit_sel != `CABX_BS_W'(i));
		end
	endgenerate

	assign res     = is_arith ? sum[`CABX_DW-1:0] :
	                 is_shift ? shifted :
	                 (fdat & keep_mask);
	assign c_out   = is_arith ? sum[`CABX_DW] : fdat[0];
	assign dc_out  = nib[`CABX_NIB_W];
	assign z_out   = (res == `CABX_ACC_RST);
	assign bit_val = fdat[bit_sel];
endmodule : cabx_alu

// ---- src/cabx_exec.sv ----
// Purpose: execution of add, add with carry, arithmetic shift, bit clear,
//          bit test with skip and relative jump inside the core
// Assumes: decoder presents one operation per cycle with op_valid; register
//          file read is combinational on file_rd_addr; pc_inc is the
//          already incremented program counter of the operation
// Notes:   file writes leave one cycle late and are forwarded to the next read
`timescale 1ns/100ps
`include "cabx_params.svh"
module cabx_exec (
	input  wire logic                      mclk,            // core instruction clock
	input  wire logic                      rst_b,           // async reset, low active
	input  wire logic                      clk_en,          // freezes all state when low
	input  wire logic                      op_valid,        // operation presented
	input  wire cabx_pkg::cabx_op_t        op_code,         // decoded operation
	input  wire logic                      op_dest,         // 0 accumulator, 1 file
	input  wire logic [`CABX_FA_W-1:0]     op_file,         // file address in bank
	input  wire logic [`CABX_BS_W-1:0]     op_bit,          // bit position
	input  wire logic [`CABX_OFS_W-1:0]    op_offset,       // signed jump offset
	input  wire logic [`CABX_PC_W-1:0]     pc_inc,          // incremented program counter
	input  wire logic [`CABX_DW-1:0]       file_rd_data,    // register file read data
	output logic      [`CABX_FA_W-1:0]     file_rd_addr,    // register file read address
	output logic                           op_taken,        // operation executed this cycle
	output logic                           nop_slot,        // cycle runs as no-op
	output logic                           file_we_ff,      // file write strobe
	output logic      [`CABX_FA_W-1:0]     file_wr_addr_ff, // file write address
	output logic      [`CABX_DW-1:0]       file_wr_data_ff, // file write data
	output logic      [`CABX_DW-1:0]       acc_ff,          // working register
	output logic                           carry_ff,        // carry flag
	output logic                           digit_carry_flag_ff, // digit carry flag
	output logic                           zero_ff,         // zero flag
	output logic                           pc_load_ff,      // load program counter
	output logic      [`CABX_PC_W-1:0]     pc_target_ff,    // jump target
	output logic                           discard_ff       // drop fetched instruction
);
	cabx_pkg::cabx_state_t   state_ff;
	cabx_pkg::cabx_state_t   nxt_state;

	wire                     fwd_hit;
	wire [`CABX_DW-1:0]      fdat;
	wire [`CABX_DW-1:0]      alu_res;
	wire                     alu_c;
	wire                     alu_dc;
	wire                     alu_z;
	wire                     alu_arith;
	wire                     alu_shift;
	wire                     alu_bit;
	wire                     exec;
	wire                     is_bclr;
	wire                     is_test;
	wire                     is_jump;
	wire                     skip_hit;
	wire                     wr_acc;
	wire                     wr_file;
	wire                     upd_c;
	wire                     upd_z;
	wire                     upd_dc;
	wire                     slot_req;
	wire [`CABX_PC_W-1:0]    ofs_ext;
	wire [`CABX_PC_W-1:0]    nxt_target;

	// read address is the operand address directly
	assign file_rd_addr = op_file;

	// a file write still in flight is newer than the register file copy
	assign fwd_hit = file_we_ff && (file_wr_addr_ff == op_file);
	assign fdat    = fwd_hit ? file_wr_data_ff : file_rd_data;

	cabx_alu u_alu (
		.op       (op_code),
		.acc      (acc_ff),
		.fdat     (fdat),
		.carry_in (carry_ff),
		.bit_sel  (op_bit),
		.res      (alu_res),
		.c_out    (alu_c),
		.dc_out   (alu_dc),
		.z_out    (alu_z),
		.is_arith (alu_arith),
		.is_shift (alu_shift),
		.bit_val  (alu_bit)
	);

	// the slot after a skip or jump swallows whatever is presented
	assign nop_slot = (state_ff == cabx_pkg::cabx_st_nop);
	assign exec     = clk_en && op_valid && !nop_slot;
	assign op_taken = exec;

	assign is_bclr  = (op_code == cabx_pkg::clear_file_bit);
	assign is_test  = (op_code == cabx_pkg::test_bit_skip_if_clear);
	assign is_jump  = (op_code == cabx_pkg::relative_jump);
	assign skip_hit = is_test && !alu_bit;
	assign slot_req = exec && (skip_hit || is_jump);

	assign wr_acc  = exec && (alu_arith || alu_shift) && !op_dest;
	assign wr_file = exec && (((alu_arith || alu_shift) && op_dest) || is_bclr);
	assign upd_c   = exec && (alu_arith || alu_shift);
	assign upd_z   = exec && (alu_arith || alu_shift);
	assign upd_dc  = exec && alu_arith;

	// sign extend the offset; target is incremented counter plus offset
	assign ofs_ext    = {{(`CABX_PC_W-`CABX_OFS_W){op_offset[`CABX_OFS_W-1]}}, op_offset};
	assign nxt_target = pc_inc + ofs_ext;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cabx_pkg::cabx_st_exec: begin
				if (slot_req) begin
					nxt_state = cabx_pkg::cabx_st_nop;
				end
			end
			cabx_pkg::cabx_st_nop: begin
				nxt_state = cabx_pkg::cabx_st_exec;
			end
			default: begin
				nxt_state = cabx_pkg::cabx_st_exec;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= cabx_pkg::cabx_st_exec;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc_ff <= `CABX_ACC_RST;
		end else if (wr_acc) begin
			acc_ff <= alu_res;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			carry_ff <= `CABX_FLAG_RST;
		end else if (upd_c) begin
			carry_ff <= alu_c;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			digit_carry_flag_ff <= `CABX_FLAG_RST;
		end else if (upd_dc) begin
			digit_carry_flag_ff <= alu_dc;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			zero_ff <= `CABX_FLAG_RST;
		end else if (upd_z) begin
			zero_ff <= alu_z;
		end
	end

	// write strobe is set in the cycle after the executing cycle and holds longer while clk_en is low
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			file_we_ff <= 1'b0;
		end else if (clk_en) begin
			file_we_ff <= wr_file;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			file_wr_addr_ff <= `CABX_FA_RST;
			file_wr_data_ff <= `CABX_ACC_RST;
		end else if (wr_file) begin
			file_wr_addr_ff <= op_file;
			file_wr_data_ff <= alu_res;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pc_load_ff <= 1'b0;
		end else if (clk_en) begin
			pc_load_ff <= exec && is_jump;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pc_target_ff <= `CABX_PC_RST;
		end else if (exec && is_jump) begin
			pc_target_ff <= nxt_target;
		end
	end

	// tells fetch that the instruction now presented will not run
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			discard_ff <= 1'b0;
		end else if (clk_en) begin
			discard_ff <= slot_req;
		end
	end
endmodule : cabx_exec

// ---- test/cabx_exec_asserts.sv ----
// Purpose: checker of the execution block ports
// Assumes: bound into cabx_exec
// Notes:   file operand is forwarded the same way the block does
`timescale 1ns/100ps
`include "cabx_params.svh"
module cabx_exec_asserts (
	input wire logic			mclk,		// clock
	input wire logic			rst_b,		// reset
	input wire logic			op_taken,	// op executes
	input wire cabx_pkg::cabx_op_t		op_code,	// op
	input wire logic			op_dest,	// destination
	input wire logic [`CABX_FA_W-1:0]	op_file,	// file address
	input wire logic [`CABX_BS_W-1:0]	op_bit,		// bit
	input wire logic [`CABX_OFS_W-1:0]	op_offset,	// offset
	input wire logic [`CABX_PC_W-1:0]	pc_inc,		// next pc
	input wire logic [`CABX_DW-1:0]		file_rd_data,	// read data
	input wire logic			nop_slot,	// no-op cycle
	input wire logic			file_we_ff,	// write strobe
	input wire logic [`CABX_FA_W-1:0]	file_wr_addr_ff,// write address
	input wire logic [`CABX_DW-1:0]		file_wr_data_ff,// write data
	input wire logic [`CABX_DW-1:0]		acc_ff,		// accumulator
	input wire logic			carry_ff,	// carry
	input wire logic			digit_carry_flag_ff, // digit carry
	input wire logic			zero_ff,	// zero
	input wire logic			pc_load_ff,	// pc load
	input wire logic [`CABX_PC_W-1:0]	pc_target_ff,	// target
	input wire logic			discard_ff	// drop fetch
);
	wire [7:0]	fwd = (file_we_ff && file_wr_addr_ff == op_file) ? file_wr_data_ff : file_rd_data;
	wire [7:0]	asum = acc_ff + fwd;
	wire [7:0]	csum = acc_ff + fwd + {7'h00, carry_ff};
	wire [14:0]	tgt = pc_inc + {{6{op_offset[8]}}, op_offset};
	wire		jmp = op_taken && op_code == cabx_pkg::relative_jump;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_slot_refuse: assert property (nop_slot |-> !op_taken) else $error("op taken in no-op slot");
	chk_jump_slot: assert property (jmp |=> pc_load_ff && nop_slot && discard_ff) else $error("jump slot");
	chk_jump_target: assert property (jmp |=> pc_target_ff == $past(tgt)) else $error("jump target");
	chk_skip_clear: assert property (op_taken && op_code == cabx_pkg::test_bit_skip_if_clear
		|=> nop_slot != $past(fwd[op_bit])) else $error("skip decision");
	chk_flags_kept: assert property (op_taken && op_code > cabx_pkg::arith_shift_right_file
		|=> $stable({carry_ff, digit_carry_flag_ff, zero_ff})) else $error("flags changed");
	chk_add_acc: assert property (op_taken && op_code == cabx_pkg::add_acc_to_file && !op_dest
		|=> acc_ff == $past(asum)) else $error("add result");
	chk_add_carry: assert property (op_taken && op_code == cabx_pkg::add_acc_file_with_carry && !op_dest
		|=> acc_ff == $past(csum)) else $error("add with carry result");
	chk_shift_carry: assert property (op_taken && op_code == cabx_pkg::arith_shift_right_file
		|=> carry_ff == $past(fwd[0])) else $error("shift carry");
	chk_clear_write: assert property (op_taken && op_code == cabx_pkg::clear_file_bit
		|=> file_we_ff && file_wr_addr_ff == $past(op_file)) else $error("bit clear write");
endmodule : cabx_exec_asserts
bind cabx_exec cabx_exec_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .op_taken(op_taken), .op_code(op_code),
	.op_dest(op_dest), .op_file(op_file), .op_bit(op_bit), .op_offset(op_offset), .pc_inc(pc_inc),
	.file_rd_data(file_rd_data), .nop_slot(nop_slot), .file_we_ff(file_we_ff), .file_wr_addr_ff(file_wr_addr_ff),
	.file_wr_data_ff(file_wr_data_ff), .acc_ff(acc_ff), .carry_ff(carry_ff), .zero_ff(zero_ff),
	.digit_carry_flag_ff(digit_carry_flag_ff), .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff),
	.discard_ff(discard_ff));

// ---- test/cabx_exec_tb.sv ----
// Purpose: self-checking bench of the execution block
// Assumes: register file modelled here, written on the write strobe
// Notes:   expected state noted per op, compared the cycle after it is taken
`timescale 1ns/100ps
`include "cabx_params.svh"
module cabx_exec_tb;
	logic			mclk, rst_b, clk_en, op_valid, op_dest, op_taken, nop_slot, file_we_ff;
	logic			carry_ff, digit_carry_flag_ff, zero_ff, pc_load_ff, discard_ff, pend, mc, mdc, mz;
	cabx_pkg::cabx_op_t	op_code;
	logic [6:0]		op_file, file_rd_addr, file_wr_addr_ff, mwa;
	logic [2:0]		op_bit;
	logic [8:0]		op_offset;
	logic [14:0]		pc_inc, pc_target_ff, mpt;
	logic [7:0]		file_rd_data, file_wr_data_ff, acc_ff, ma, mwd;
	logic [7:0]		rf [128];
	logic [7:0]		mm [128];
	logic [43:0]		q [$];
	int			errors, compares;
	assign file_rd_data = rf[file_rd_addr];
	cabx_exec u_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
		.op_dest(op_dest), .op_file(op_file), .op_bit(op_bit), .op_offset(op_offset), .pc_inc(pc_inc),
		.file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr), .op_taken(op_taken), .nop_slot(nop_slot),
		.file_we_ff(file_we_ff), .file_wr_addr_ff(file_wr_addr_ff), .file_wr_data_ff(file_wr_data_ff),
		.acc_ff(acc_ff), .carry_ff(carry_ff), .digit_carry_flag_ff(digit_carry_flag_ff), .zero_ff(zero_ff),
		.pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff), .discard_ff(discard_ff));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) if (file_we_ff) rf[file_wr_addr_ff] <= file_wr_data_ff;
	task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch state expected %h seen %h", exp, seen);
		end
	endtask : chk
	always @(negedge mclk) begin
		if (pend) chk({acc_ff, carry_ff, digit_carry_flag_ff, zero_ff, file_we_ff, file_wr_addr_ff,
			file_wr_data_ff, pc_load_ff, discard_ff, pc_target_ff}, q.size() ? q.pop_front() : 44'hX);
		pend = op_taken;
	end
	task automatic op(input cabx_pkg::cabx_op_t c, input logic d, input logic [6:0] f, input logic [2:0] b,
		input logic [8:0] k);
		logic [8:0]	s;
		logic [4:0]	h;
		logic [7:0]	v;
		logic		sk;
		logic		ew;
		logic		en;
		logic		ci;
		v = mm[f];
		sk = 1'b0;
		ew = 1'b0;
		en = 3'($urandom) != 3'h0;
		ci = c == cabx_pkg::add_acc_file_with_carry && mc;
		@(posedge mclk);
		clk_en <= en;
		op_valid <= 1'b1;
		op_code <= c;
		op_dest <= d;
		op_file <= f;
		op_bit <= b;
		op_offset <= k;
		pc_inc <= 15'($urandom);
		#1;
		case (c)
			cabx_pkg::add_acc_to_file, cabx_pkg::add_acc_file_with_carry: begin
				s = ma + v + ci;
				h = ma[3:0] + v[3:0] + ci;
				v = s[7:0];
				mc = s[8];
				mdc = h[4];
				mz = v == 8'h00;
			end
			cabx_pkg::arith_shift_right_file: begin
				mc = v[0];
				v = {v[7], v[7:1]};
				mz = v == 8'h00;
			end
			cabx_pkg::clear_file_bit: v[b] = 1'b0;
			cabx_pkg::test_bit_skip_if_clear: sk = !v[b];
			default: begin
				mpt = pc_inc + {{6{k[8]}}, k};
				sk = 1'b1;
			end
		endcase
		if (c == cabx_pkg::clear_file_bit || (c < cabx_pkg::test_bit_skip_if_clear && d)) begin
			mm[f] = v;
			mwa = f;
			mwd = v;
			ew = 1'b1;
		end else if (c < cabx_pkg::test_bit_skip_if_clear) ma = v;
		q.push_back({ma, mc, mdc, mz, ew, mwa, mwd, c == cabx_pkg::relative_jump, sk, mpt});
		if (!en) begin
			@(posedge mclk);
			clk_en <= 1'b1;
		end
		if (sk) begin
			@(posedge mclk);
			op_code <= cabx_pkg::cabx_op_t'(3'($urandom_range(5)));
			op_file <= 7'($urandom);
		end
	endtask : op
	task automatic idle;
		@(posedge mclk);
		op_valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : idle
	task automatic complete_run;
		chk(44'(q.size()), 44'h0);
		$display("counts: compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	initial begin
		void'($urandom(6683));
		{rst_b, clk_en, op_valid, op_dest, op_file, op_bit, op_offset, pc_inc, pend} = '0;
		op_code = cabx_pkg::add_acc_to_file;
		{ma, mc, mdc, mz, mwa, mwd, mpt} = '0;
		for (int i = 0; i < 128; i++) rf[i] = 8'($urandom);
		rf[0] = 8'hFF;
		rf[1] = 8'h01;
		rf[2] = 8'h0F;
		mm = rf;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		op(cabx_pkg::add_acc_to_file, 1'b0, 7'h00, 3'h0, 9'h000);
		op(cabx_pkg::add_acc_to_file, 1'b0, 7'h01, 3'h0, 9'h000);
		op(cabx_pkg::add_acc_file_with_carry, 1'b1, 7'h02, 3'h0, 9'h000);
		op(cabx_pkg::arith_shift_right_file, 1'b1, 7'h00, 3'h0, 9'h000);
		op(cabx_pkg::clear_file_bit, 1'b0, 7'h00, 3'h7, 9'h000);
		op(cabx_pkg::test_bit_skip_if_clear, 1'b0, 7'h00, 3'h7, 9'h000);
		op(cabx_pkg::test_bit_skip_if_clear, 1'b0, 7'h00, 3'h0, 9'h000);
		op(cabx_pkg::relative_jump, 1'b0, 7'h00, 3'h0, 9'h100);
		op(cabx_pkg::relative_jump, 1'b0, 7'h7F, 3'h0, 9'h0FF);
		op(cabx_pkg::add_acc_to_file, 1'b1, 7'h7F, 3'h0, 9'h000);
		idle();
		$display("test directed done");
		for (int i = 0; i < 400; i++) op(cabx_pkg::cabx_op_t'(3'($urandom_range(5))), 1'($urandom), 7'($urandom),
			3'($urandom), 9'($urandom));
		idle();
		$display("test random done");
		complete_run();
	end
endmodule : cabx_exec_tb
